// File: hw/buffer_mem.sv
// Internal byte memory behind the port: one write port, two read ports.
module buffer_mem
  import nonframed_select_port_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Write port
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read ports
  input wire logic [MEM_AW-1:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [MEM_AW-1:0] raddr_b,
  output logic [7:0] rdata_b
);

  logic [7:0] mem_r [0:MEM_BYTES-1];

  // Stores one byte per cycle; no reset, contents are undefined at power up.
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  // Both read ports are combinational.
  assign rdata_a = mem_r[raddr_a];
  assign rdata_b = mem_r[raddr_b];

endmodule

// File: hw/parallel_nonframed_select_fifo_port.sv
// Parallel asynchronous FIFO port with its Avalon-MM control registers.
//
// Contract
// - After eight bytes handshake goes high; low again when FIFO ready.
// - Packet event pin goes low after a packet was transmitted.
// - Receive event only for valid packets: address match and good CRC.
// - Offset byte within page; page byte low bits, bit 7 single transfer.
// - FIFO byte n moves to or from pointer plus n.
// - Single write takes eight bytes; only the one data byte is stored.
// - Data write uses operation 11; data latched on write strobe rise.
// - Last byte written lands in FIFO byte 0.
// - Pointer auto-increments per block, wrapping inside its page.
// - Data read: operation 11, each read strobe fall drives next byte.
// - Reads output the last FIFO byte first, byte 0 last.
// - No stream data is reachable in this mode.
// - Mode entered when both select pins are high at reset release.
// - Operation 10 read returns the status byte in one access.
// - Status busy bit mirrors the handshake line.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
module parallel_nonframed_select_fifo_port
  import nonframed_select_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Host parallel port
  input wire logic [1:0] port_operation_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic transfer_handshake,
  output logic packet_event_n,
  // Configuration pins
  input wire logic parallel_source_select,
  input wire logic nonframed_select,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------

  // Address of FIFO slot idx; the offset wraps inside the page.
  function automatic logic [MEM_AW-1:0] slot_addr(
    input logic [MEM_AW-1:0] ptr,
    input logic [2:0] idx
  );
    logic [7:0] off;
    off = ptr[7:0] + {5'h00, idx};
    return {ptr[MEM_AW-1:8], off};
  endfunction

  // Merges a write into a register under the byte enables.
  function automatic logic [31:0] merge_be(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  host_pins_type pins_now;
  host_pins_type sync1_r;
  host_pins_type sync2_r;
  host_pins_type sync3_r;
  proc_state_type state_r;
  logic [1:0] start_cnt_r;
  logic mode_active_r;
  logic [2:0] count_r;
  logic [2:0] idx_r;
  logic [7:0] fifo_r [0:FIFO_DEPTH-1];
  logic [MEM_AW-1:0] ptr_r;
  logic handshake_r;
  logic packet_event_n_r;
  logic [7:0] data_out_r;
  logic data_oe_r;
  logic lock_lost_r;
  logic [15:0] node_addr_r;
  logic [15:0] alt_addr_r;
  logic [MEM_AW-1:0] mem_addr_r;
  logic [31:0] readdata_r;
  logic waitrequest_r;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic wr_take;
  logic rd_take;
  logic [7:0] status_byte;
  logic port_we;
  logic [MEM_AW-1:0] port_waddr;
  logic [7:0] port_wdata;
  logic bus_take;
  logic bus_wr;
  logic bus_rd;
  logic mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] fetch_data;
  logic [7:0] bus_mem_data;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic tx_set;
  logic rx_set;
  logic evt_clear;

  // ------------------------------------------------------------------
  // Pin synchroniser and strobe edges
  // ------------------------------------------------------------------
  assign pins_now = '{parallel_source_select, nonframed_select,
                      port_operation_select, read_strobe_n,
                      write_strobe_n, data_in};

  // Three stages: two for metastability, the third for edge detection.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sync1_r <= PINS_IDLE;
      sync2_r <= PINS_IDLE;
      sync3_r <= PINS_IDLE;
    end
    else
    begin
      sync1_r <= pins_now;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign wr_rise = sync2_r.wr_n && !sync3_r.wr_n;
  assign rd_fall = !sync2_r.rd_n && sync3_r.rd_n;
  assign rd_rise = sync2_r.rd_n && !sync3_r.rd_n;
  // Data is taken from the stage that shows the rising write strobe.
  assign wr_take = wr_rise && (state_r == ST_OPEN) && sync2_r.rd_n &&
                   (sync2_r.op == OP_DATA || sync2_r.op == OP_POINTER);
  assign rd_take = rd_fall && (state_r == ST_OPEN) &&
                   (sync2_r.op == OP_DATA) && sync2_r.wr_n;

  // ------------------------------------------------------------------
  // Mode capture after reset release
  // ------------------------------------------------------------------

  // Waits until the synchronised pins are valid, then latches the mode once.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      start_cnt_r <= 2'h0;
      mode_active_r <= 1'b0;
    end
    else if (start_cnt_r != START_WAIT)
    begin
      start_cnt_r <= start_cnt_r + 2'h1;
      if (start_cnt_r == START_WAIT - 2'h1)
      begin
        mode_active_r <= sync2_r.source_sel && sync2_r.nonframed_sel;
      end
    end
  end

  // ------------------------------------------------------------------
  // Processing state machine
  // ------------------------------------------------------------------

  // Sequences block collection, memory stores, pointer loads and fetches.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_HALT;
      idx_r <= 3'h0;
    end
    else
    begin
      case (state_r)
        ST_HALT:
        begin
          if (start_cnt_r == START_WAIT)
          begin
            state_r <= mode_active_r ? ST_OPEN : ST_IDLE_MODE;
          end
        end
        ST_OPEN:
        begin
          idx_r <= 3'h0;
          if (wr_take && count_r == LAST_SLOT)
          begin
            state_r <= (sync2_r.op == OP_DATA) ? ST_STORE : ST_POINTER;
          end
          else if (rd_take && count_r == LAST_SLOT)
          begin
            state_r <= ST_FETCH;
          end
        end
        ST_STORE:
        begin
          idx_r <= idx_r + 3'h1;
          if (idx_r == LAST_SLOT)
          begin
            state_r <= ST_FETCH;
          end
        end
        ST_POINTER:
        begin
          // A single-byte write stores and returns; a load prefetches.
          state_r <= fifo_r[1][SINGLE_BIT] ? ST_OPEN : ST_FETCH;
        end
        ST_FETCH:
        begin
          idx_r <= idx_r + 3'h1;
          if (idx_r == LAST_SLOT)
          begin
            state_r <= ST_OPEN;
          end
        end
        ST_IDLE_MODE:
        begin
          state_r <= ST_IDLE_MODE;
        end
        default:
        begin
          state_r <= ST_HALT;
        end
      endcase
    end
  end

  // Handshake is high whenever the FIFO is not open to the host.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      handshake_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        ST_OPEN:
          handshake_r <= (wr_take || rd_take) && count_r == LAST_SLOT;
        ST_POINTER:
          handshake_r <= !fifo_r[1][SINGLE_BIT];
        ST_FETCH:
          handshake_r <= idx_r != LAST_SLOT;
        ST_HALT:
          handshake_r <= !(start_cnt_r == START_WAIT && mode_active_r);
        default:
          handshake_r <= 1'b1;
      endcase
    end
  end

  // Counts host strobes inside a block; zero whenever the FIFO reopens.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      count_r <= 3'h0;
    end
    else if (state_r != ST_OPEN)
    begin
      count_r <= 3'h0;
    end
    else if (wr_take || rd_take)
    begin
      count_r <= count_r + 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // FIFO storage
  // ------------------------------------------------------------------

  // Writes shift toward higher slots; fetches fill slot idx from memory.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
        fifo_r[i] <= 8'h00;
      end
    end
    else if (wr_take)
    begin
      fifo_r[0] <= sync2_r.data;
      for (int i = 1; i < FIFO_DEPTH; i++)
      begin
        fifo_r[i] <= fifo_r[i-1];
      end
    end
    else if (state_r == ST_FETCH)
    begin
      fifo_r[idx_r] <= fetch_data;
    end
  end

  // ------------------------------------------------------------------
  // Memory address pointer
  // ------------------------------------------------------------------

  // Loaded from slots 1 and 0; advances by a block inside the same page.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ptr_r <= '0;
    end
    else if (state_r == ST_POINTER && !fifo_r[1][SINGLE_BIT])
    begin
      ptr_r <= {fifo_r[1][1:0], fifo_r[0]};
    end
    else if ((state_r == ST_STORE && idx_r == LAST_SLOT) ||
             (rd_take && count_r == LAST_SLOT))
    begin
      ptr_r <= {ptr_r[MEM_AW-1:8], ptr_r[7:0] + BLOCK_STEP};
    end
  end

  // ------------------------------------------------------------------
  // Host read data
  // ------------------------------------------------------------------
  assign status_byte = {3'h0, !packet_event_n_r, 1'b0,
                        state_r == ST_OPEN && count_r == 3'h0, 1'b0,
                        handshake_r};

  // Drives a byte from the falling read strobe until the strobe rises.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      data_out_r <= 8'h00;
      data_oe_r <= 1'b0;
    end
    else if (rd_fall && sync2_r.wr_n && sync2_r.op == OP_POINTER &&
             mode_active_r)
    begin
      data_out_r <= status_byte;
      data_oe_r <= 1'b1;
    end
    else if (rd_take)
    begin
      data_out_r <= fifo_r[LAST_SLOT - count_r];
      data_oe_r <= 1'b1;
    end
    else if (rd_rise)
    begin
      data_oe_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Memory access
  // ------------------------------------------------------------------
  assign port_we = (state_r == ST_STORE) ||
                   (state_r == ST_POINTER && fifo_r[1][SINGLE_BIT]);
  assign port_waddr = (state_r == ST_STORE) ? slot_addr(ptr_r, idx_r) :
                      {fifo_r[1][1:0], fifo_r[0]};
  assign port_wdata = (state_r == ST_STORE) ? fifo_r[idx_r] : fifo_r[2];
  // The port owns the write port; bus writes wait for a free cycle.
  assign mem_we = port_we || (bus_wr && avs_address == REG_MEM_DATA &&
                              avs_byteenable[0]);
  assign mem_waddr = port_we ? port_waddr : mem_addr_r;
  assign mem_wdata = port_we ? port_wdata : avs_writedata[7:0];

  buffer_mem u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(slot_addr(ptr_r, idx_r)),
    .rdata_a(fetch_data),
    .raddr_b(mem_addr_r),
    .rdata_b(bus_mem_data)
  );

  // ------------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------------
  assign bus_take = (avs_read || avs_write) && waitrequest_r && !port_we;
  assign bus_wr = bus_take && avs_write;
  assign bus_rd = bus_take && avs_read;
  assign tx_set = bus_wr && avs_address == REG_EVENT &&
                  avs_byteenable[0] && avs_writedata[EVT_TX_DONE];
  assign evt_clear = bus_wr && avs_address == REG_EVENT &&
                     avs_byteenable[0] && avs_writedata[EVT_CLEAR];
  assign rx_set = bus_wr && avs_address == REG_RX_REPORT &&
                  avs_writedata[RX_CRC_OK] &&
                  (avs_writedata[15:0] == node_addr_r ||
                   avs_writedata[15:0] == alt_addr_r);
  assign wr_word = merge_be(32'h0, avs_writedata, avs_byteenable);

  // Waitrequest drops for exactly one cycle per accepted access.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      waitrequest_r <= 1'b1;
    end
    else
    begin
      waitrequest_r <= !bus_take;
    end
  end

  // Software-written control and address registers.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      lock_lost_r <= 1'b0;
      node_addr_r <= NODE_ADDR_RESET;
      alt_addr_r <= ALT_ADDR_RESET;
      mem_addr_r <= '0;
    end
    else if (bus_wr)
    begin
      case (avs_address)
        REG_CONTROL:
          if (avs_byteenable[0]) lock_lost_r <= wr_word[CTRL_LOCK_LOST];
        REG_NODE_ADDR:
          node_addr_r <= 16'(merge_be({16'h0, node_addr_r}, avs_writedata,
                                      avs_byteenable));
        REG_ALT_ADDR:
          alt_addr_r <= 16'(merge_be({16'h0, alt_addr_r}, avs_writedata,
                                     avs_byteenable));
        REG_MEM_ADDR:
          mem_addr_r <= MEM_AW'(merge_be({22'h0, mem_addr_r},
                                         avs_writedata, avs_byteenable));
        default:
          lock_lost_r <= lock_lost_r;
      endcase
    end
  end

  // Packet event pin: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      packet_event_n_r <= 1'b1;
    end
    else if (tx_set || rx_set)
    begin
      packet_event_n_r <= 1'b0;
    end
    else if (evt_clear)
    begin
      packet_event_n_r <= 1'b1;
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_word = 32'h0;
    case (avs_address)
      REG_CONTROL: rd_word[CTRL_LOCK_LOST] = lock_lost_r;
      REG_EVENT: rd_word[EVT_TX_DONE] = !packet_event_n_r;
      REG_STATUS:
      begin
        rd_word[STAT_HANDSHAKE] = handshake_r;
        rd_word[STAT_MODE] = mode_active_r;
        rd_word[STAT_EMPTY] = state_r == ST_OPEN && count_r == 3'h0;
        rd_word[STAT_EVENT] = !packet_event_n_r;
      end
      REG_POINTER: rd_word[MEM_AW-1:0] = ptr_r;
      REG_NODE_ADDR: rd_word[15:0] = node_addr_r;
      REG_ALT_ADDR: rd_word[15:0] = alt_addr_r;
      REG_MEM_ADDR: rd_word[MEM_AW-1:0] = mem_addr_r;
      REG_MEM_DATA: rd_word[7:0] = bus_mem_data;
      default: rd_word = 32'h0;
    endcase
  end

  // Read data is registered in the cycle the access is accepted.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      readdata_r <= 32'h0;
    end
    else if (bus_rd)
    begin
      readdata_r <= rd_word;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
  assign transfer_handshake = handshake_r;
  assign packet_event_n = packet_event_n_r;
  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitrequest_r;

endmodule

// File: inc/nonframed_select_port_pkg.sv
// Shared constants and carrier types of the parallel asynchronous FIFO port.
package nonframed_select_port_pkg;

  // ------------------------------------------------------------------
  // Port operation codes and FIFO geometry
  // ------------------------------------------------------------------
  localparam logic [1:0] OP_POINTER = 2'h2;
  localparam logic [1:0] OP_DATA = 2'h3;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [7:0] BLOCK_STEP = 8'h08;
  localparam int SINGLE_BIT = 7;
  localparam int MEM_BYTES = 1024;
  localparam int MEM_AW = 10;
  localparam logic [1:0] START_WAIT = 2'h3;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses on the Avalon slave)
  // ------------------------------------------------------------------
  localparam logic [5:0] REG_CONTROL = 6'h00;
  localparam logic [5:0] REG_EVENT = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h08;
  localparam logic [5:0] REG_POINTER = 6'h0c;
  localparam logic [5:0] REG_NODE_ADDR = 6'h10;
  localparam logic [5:0] REG_ALT_ADDR = 6'h14;
  localparam logic [5:0] REG_RX_REPORT = 6'h18;
  localparam logic [5:0] REG_MEM_ADDR = 6'h1c;
  localparam logic [5:0] REG_MEM_DATA = 6'h20;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_LOCK_LOST = 0;
  localparam int EVT_TX_DONE = 0;
  localparam int EVT_CLEAR = 1;
  localparam int STAT_HANDSHAKE = 0;
  localparam int STAT_MODE = 1;
  localparam int STAT_EMPTY = 2;
  localparam int STAT_EVENT = 3;
  localparam int RX_CRC_OK = 16;
  localparam int PSTAT_EVENT = 4;
  localparam int PSTAT_EMPTY = 2;
  localparam int PSTAT_BUSY = 0;
  localparam logic [15:0] NODE_ADDR_RESET = 16'hffff;
  localparam logic [15:0] ALT_ADDR_RESET = 16'hffff;

  // ------------------------------------------------------------------
  // Carrier of the host pins as they pass the synchroniser
  // ------------------------------------------------------------------
  typedef struct packed {
    logic source_sel;
    logic nonframed_sel;
    logic [1:0] op;
    logic rd_n;
    logic wr_n;
    logic [7:0] data;
  } host_pins_type;

  localparam host_pins_type PINS_IDLE = '{1'b0, 1'b0, 2'h0, 1'b1, 1'b1,
                                          8'h00};

  // Processing states of the FIFO.
  typedef enum logic [5:0] {
    ST_HALT = 6'h01,
    ST_OPEN = 6'h02,
    ST_STORE = 6'h04,
    ST_POINTER = 6'h08,
    ST_FETCH = 6'h10,
    ST_IDLE_MODE = 6'h20
  } proc_state_type;

endpackage

// File: verif/host_model.sv
// Behavioural host driving the parallel port strobes and data bus.
module host_model
  import nonframed_select_port_pkg::*;
(
  // Clock and device outputs
  input wire logic clk_sys,
  input wire logic transfer_handshake,
  input wire logic [7:0] data_out,
  // Host driven pins
  output logic [1:0] port_operation_select,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet pins at time zero.
  initial
  begin
    port_operation_select = OP_DATA;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = 8'h00;
  end
  // Holds off until the FIFO is free again.
  task automatic idle();
    do
      @(negedge clk_sys);
    while (transfer_handshake !== 1'b0);
  endtask
  // One write strobe; the released bus shows the inverse value.
  task automatic wr(input logic [1:0] op, input logic [7:0] d);
    @(posedge clk_sys);
    port_operation_select <= op;
    data_in <= d;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    write_strobe_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    data_in <= ~d;
    repeat (2) @(posedge clk_sys);
  endtask
  // Sends a whole block, element 0 first.
  task automatic send8(input logic [1:0] op, input logic [7:0] q [8]);
    idle();
    for (int i = 0; i < 8; i++)
      wr(op, q[i]);
  endtask
  // One read strobe; the byte is taken while the device drives it.
  task automatic rd(input logic [1:0] op, output logic [7:0] d);
    @(posedge clk_sys);
    port_operation_select <= op;
    read_strobe_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    d = data_out;
    read_strobe_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// File: verif/port_asserts.sv
// Concurrent checks on the host port pins of the FIFO port.
module port_asserts
  import nonframed_select_port_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Watched port signals
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [1:0] port_operation_select,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic transfer_handshake,
  input wire logic packet_event_n,
  input wire logic parallel_source_select,
  input wire logic nonframed_select,
  input wire logic avs_write
);
  logic [3:0] quiet_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Counts cycles since either host strobe last moved.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      quiet_r <= 4'hf;
    else if (!$stable(read_strobe_n) || !$stable(write_strobe_n))
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
  end
  AST_HS_RELEASE:
  assert property (transfer_handshake && parallel_source_select
    && nonframed_select |-> ##[0:40] !transfer_handshake)
    else $error("handshake held high too long");
  AST_HS_CAUSE:
  assert property ($rose(transfer_handshake) |-> quiet_r < 4'h8)
    else $error("handshake rose without host strobes");
  AST_BUSY_MIRROR:
  assert property ($rose(data_oe) && port_operation_select == OP_POINTER
    && $stable(transfer_handshake)
    |-> data_out[PSTAT_BUSY] == transfer_handshake)
    else $error("busy bit differs from handshake");
  AST_OE_CAUSE:
  assert property (data_oe |-> !$past(read_strobe_n, 3))
    else $error("bus driven without read strobe");
  AST_OE_WR:
  assert property (data_oe |-> $past(write_strobe_n, 3))
    else $error("bus driven during write strobe");
  AST_EVT_SET:
  assert property ($fell(packet_event_n) |-> $past(avs_write)
    || $past(avs_write, 2))
    else $error("event pin fell without cause");
  AST_EVT_CLR:
  assert property ($rose(packet_event_n) |-> $past(avs_write)
    || $past(avs_write, 2))
    else $error("event pin rose without clear");
  AST_MODE:
  assert property ($fell(transfer_handshake)
    |-> $past(parallel_source_select && nonframed_select, 4))
    else $error("port opened outside its mode");
  cover property ($rose(transfer_handshake));
  cover property ($rose(data_oe) && port_operation_select == OP_POINTER);
  cover property ($fell(packet_event_n));
endmodule

bind parallel_nonframed_select_fifo_port port_asserts chk (.clk_sys(clk_sys),
  .reset(reset), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n),
  .port_operation_select(port_operation_select), .data_out(data_out),
  .data_oe(data_oe), .transfer_handshake(transfer_handshake),
  .packet_event_n(packet_event_n),
  .parallel_source_select(parallel_source_select),
  .nonframed_select(nonframed_select), .avs_write(avs_write));

// File: verif/tb_top.sv
// Self-checking bench of the parallel asynchronous FIFO port.
module tb_top
  import nonframed_select_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] op;
  logic rd_n, wr_n, hs, pe_n, rd, wr, wreq;
  logic [7:0] din, dout, b;
  logic [5:0] a;
  logic [31:0] wd, rq, q, seed = 32'd73;
  logic [31:0] ev [4] = '{32'h10123, 32'h1ffff, 32'h00123, 32'h10456};
  logic [7:0] mem [1024];
  logic [7:0] q8 [8];
  logic sel = 1'b1;
  int num_errors = 0;
  int check_count = 0;
  int ptr;
  always #25 clk_sys = ~clk_sys;
  parallel_nonframed_select_fifo_port dut (.clk_sys(clk_sys), .reset(reset),
    .port_operation_select(op), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .data_in(din), .data_out(dout), .data_oe(),
    .transfer_handshake(hs), .packet_event_n(pe_n),
    .parallel_source_select(sel), .nonframed_select(1'b1),
    .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rq), .avs_waitrequest(wreq));
  host_model host (.clk_sys(clk_sys), .transfer_handshake(hs),
    .data_out(dout), .port_operation_select(op), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .data_in(din));
  task automatic chk(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // One Avalon access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [5:0] ad,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    a <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
      @(posedge clk_sys);
    while (wreq !== 1'b0);
    r = rq;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic loadp(input logic [7:0] pg, off);
    q8 = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, pg, off};
    host.send8(OP_POINTER, q8);
    ptr = {pg[1:0], off};
  endtask
  task automatic wblk();
    for (int i = 0; i < 8; i++)
      q8[i] = rnd();
    host.send8(OP_DATA, q8);
    for (int i = 0; i < 8; i++)
      mem[ptr + i] = q8[7 - i];
    ptr = (ptr & 'h300) | ((ptr + 8) & 'hff);
  endtask
  task automatic rblk();
    host.idle();
    for (int i = 7; i >= 0; i--)
    begin
      host.rd(OP_DATA, b);
      chk(b, mem[ptr + i], "read byte");
    end
    chk(hs, 1'b1, "busy after reads");
    ptr = (ptr & 'h300) | ((ptr + 8) & 'hff);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hung handshake or bus.
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
  // Main sequence.
  initial
  begin
    {a, wd, wr, rd} = '0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    host.idle();
    host.rd(OP_POINTER, b);
    chk(b, 8'h04, "idle status");
    bus(1'b0, REG_NODE_ADDR, 32'h0, q);
    chk(q, 32'hffff, "node address reset");
    bus(1'b0, 6'h3c, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, REG_CONTROL, 32'h0, q);
    loadp(8'h01, 8'hc0);
    wblk();
    wblk();
    loadp(8'h01, 8'hc0);
    rblk();
    rblk();
    loadp(8'h02, 8'h00);
    wblk();
    loadp(8'h02, 8'hf8);
    wblk();
    rblk();
    $display("block tests done");
    b = rnd();
    q8 = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, b, 8'h82, 8'h03};
    host.send8(OP_POINTER, q8);
    mem['h203] = b;
    loadp(8'h02, 8'h00);
    rblk();
    bus(1'b0, REG_POINTER, 32'h0, q);
    chk(q, ptr, "pointer register");
    $display("single byte test done");
    bus(1'b1, REG_EVENT, 32'h1, q);
    host.rd(OP_POINTER, b);
    chk(b, 8'h14, "event status");
    chk(pe_n, 1'b0, "event pin");
    bus(1'b1, REG_EVENT, 32'h2, q);
    bus(1'b1, REG_NODE_ADDR, 32'h0123, q);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, REG_RX_REPORT, ev[i], q);
      repeat (3) @(negedge clk_sys);
      chk(pe_n, !(ev[i][16] && (ev[i][15:0] == 16'h0123
        || ev[i][15:0] == ALT_ADDR_RESET)), "receive event");
      bus(1'b1, REG_EVENT, 32'h2, q);
    end
    $display("event tests done");
    sel <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (5) @(posedge clk_sys);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(q, 32'h1, "status outside mode");
    $display("mode test done");
    test_done();
  end
endmodule
